//--- rtl/mphp_pkg.sv
// Shared constants of the modem parallel host port
`default_nettype none
package mphp_pkg;
    // Register indices on the three index lines
    localparam logic [2:0] MPHP_IDX_DATA = 3'h0;
    localparam logic [2:0] MPHP_IDX_IRQ_EN = 3'h1;
    localparam logic [2:0] MPHP_IDX_IRQ_ID = 3'h2;
    localparam logic [2:0] MPHP_IDX_LINE_CTRL = 3'h3;
    localparam logic [2:0] MPHP_IDX_MODEM_CTRL = 3'h4;
    localparam logic [2:0] MPHP_IDX_LINE_STAT = 3'h5;
    localparam logic [2:0] MPHP_IDX_MODEM_STAT = 3'h6;
    localparam logic [2:0] MPHP_IDX_SCRATCH = 3'h7;
    // Interrupt source positions, shared by enable and pending vectors
    localparam int MPHP_SRC_RX_DATA = 0;
    localparam int MPHP_SRC_THR_EMPTY = 1;
    localparam int MPHP_SRC_RX_ERR = 2;
    localparam int MPHP_SRC_MODEM = 3;
    // Line status bit positions
    localparam int MPHP_LSR_DATA_READY = 0;
    localparam int MPHP_LSR_RX_ERR = 1;
    localparam int MPHP_LSR_THR_EMPTY = 5;
    // Interrupt identification codes
    localparam logic [7:0] MPHP_ID_NONE = 8'h01;
    localparam logic [7:0] MPHP_ID_RX_ERR = 8'h06;
    localparam logic [7:0] MPHP_ID_RX_DATA = 8'h04;
    localparam logic [7:0] MPHP_ID_THR_EMPTY = 8'h02;
    localparam logic [7:0] MPHP_ID_MODEM = 8'h00;
    // Reset values
    localparam logic [7:0] MPHP_RST_BYTE = 8'h00;
    localparam logic [3:0] MPHP_RST_IRQ_EN = 4'h0;
    localparam logic MPHP_RST_THR_EMPTY = 1'b1;
    // Settling time after reset release
    localparam int unsigned MPHP_CLK_HZ = 125_000_000;
    localparam int unsigned MPHP_SETTLE_MS = 25;
    localparam int unsigned MPHP_SETTLE_CYC = MPHP_SETTLE_MS * (MPHP_CLK_HZ / 1000);
    // Readiness states
    typedef enum logic [1:0] {
        MPHP_ST_SETTLE = 2'b01,
        MPHP_ST_READY = 2'b10
    } mphp_state_e;
endpackage
`default_nettype wire

//--- rtl/mphp_access_if.sv
// Decoded host access carrier between decoder and register core
`default_nettype none
interface mphp_access_if;
    logic wr_pulse;
    logic rd_pulse;
    logic rd_active;
    logic [2:0] index;
    logic [7:0] wdata;
    modport dec (output wr_pulse, output rd_pulse, output rd_active, output index, output wdata);
    modport core (input wr_pulse, input rd_pulse, input rd_active, input index, input wdata);
endinterface
`default_nettype wire

//--- rtl/mphp_bus_decode.sv
// Host strobe decoder: turns chip select and strobes into access pulses
`default_nettype none
module mphp_bus_decode (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic host_select_n_i,
    input wire logic host_write_strobe_n_i,
    input wire logic host_read_strobe_n_i,
    input wire logic [2:0] host_reg_index_i,
    input wire logic [7:0] host_data_bus_i,
    input wire logic ready_i,
    mphp_access_if.dec acc
);
    logic wr_act;
    logic rd_act;
    logic wr_prev_r;
    logic rd_prev_r;

    // Strobes count only under chip select; both strobes at once is ignored
    assign wr_act = ready_i & ~host_select_n_i & ~host_write_strobe_n_i & host_read_strobe_n_i;
    assign rd_act = ready_i & ~host_select_n_i & ~host_read_strobe_n_i & host_write_strobe_n_i;

    // One pulse at the leading edge, so a long strobe acts only once
    assign acc.wr_pulse = wr_act & ~wr_prev_r;
    assign acc.rd_pulse = rd_act & ~rd_prev_r;
    assign acc.rd_active = rd_act;
    assign acc.index = host_reg_index_i;
    assign acc.wdata = host_data_bus_i;

    // Previous strobe levels for edge detection
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_prev_r <= 1'b0;
            rd_prev_r <= 1'b0;
        end else begin
            wr_prev_r <= wr_act;
            rd_prev_r <= rd_act;
        end
    end
endmodule
`default_nettype wire

//--- rtl/mphp_host_port.sv
// Modem parallel host port: register core, interrupt and settle timer
`default_nettype none
module mphp_host_port
    import mphp_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = MPHP_SETTLE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic host_select_n_i,
    input wire logic host_write_strobe_n_i,
    input wire logic host_read_strobe_n_i,
    input wire logic [2:0] host_reg_index_i,
    input wire logic [7:0] host_data_bus_i,
    output logic [7:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    output logic host_irq_o,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_error_i,
    input wire logic tx_done_i,
    input wire logic [3:0] modem_status_i,
    output logic [7:0] tx_data_o,
    output logic tx_load_o,
    output logic [7:0] line_ctrl_o,
    output logic [7:0] modem_ctrl_o,
    output logic port_ready_o
);
    mphp_access_if acc ();
    mphp_state_e state_r;
    mphp_state_e state_nxt;
    logic [31:0] settle_cnt_r;
    logic settle_done;
    logic [3:0] irq_en_r;
    logic [7:0] rx_data_r;
    logic [7:0] scratch_r;
    logic data_ready_r;
    logic rx_err_r;
    logic thr_empty_r;
    logic thr_irq_r;
    logic [3:0] modem_prev_r;
    logic [3:0] modem_delta_r;
    logic [3:0] pending;
    logic [3:0] active;
    logic [7:0] irq_id;
    logic [7:0] line_stat;
    logic [7:0] rd_value;
    logic wr_data;
    logic rd_data;
    logic rd_id;
    logic rd_lsr;
    logic rd_msr;
    logic data_ready_nxt;
    logic rx_err_nxt;
    logic thr_empty_nxt;
    logic thr_irq_nxt;
    logic [3:0] modem_delta_nxt;

    // Assertion clock and reset, shared by every check in this module
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    mphp_bus_decode u_decode (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .host_select_n_i(host_select_n_i),
        .host_write_strobe_n_i(host_write_strobe_n_i),
        .host_read_strobe_n_i(host_read_strobe_n_i),
        .host_reg_index_i(host_reg_index_i),
        .host_data_bus_i(host_data_bus_i),
        .ready_i(port_ready_o),
        .acc(acc)
    );

    // Settle timer; a parameter so simulation can shorten 25 ms
    assign settle_done = (settle_cnt_r == 32'(SETTLE_CYCLES - 1));
    always_comb begin
        case (state_r)
            MPHP_ST_SETTLE: state_nxt = settle_done ? MPHP_ST_READY : MPHP_ST_SETTLE;
            MPHP_ST_READY: state_nxt = MPHP_ST_READY;
            default: state_nxt = MPHP_ST_SETTLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= MPHP_ST_SETTLE;
            settle_cnt_r <= 32'h0000_0000;
            port_ready_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            settle_cnt_r <= (state_r == MPHP_ST_SETTLE) ? settle_cnt_r + 32'h0000_0001 : settle_cnt_r;
            port_ready_o <= (state_nxt == MPHP_ST_READY);
        end
    end

    // Access decodes per register index
    assign wr_data = acc.wr_pulse & (acc.index == MPHP_IDX_DATA);
    assign rd_data = acc.rd_pulse & (acc.index == MPHP_IDX_DATA);
    assign rd_id = acc.rd_pulse & (acc.index == MPHP_IDX_IRQ_ID);
    assign rd_lsr = acc.rd_pulse & (acc.index == MPHP_IDX_LINE_STAT);
    assign rd_msr = acc.rd_pulse & (acc.index == MPHP_IDX_MODEM_STAT);

    // Pending sources gated by the enable register
    assign pending[MPHP_SRC_RX_DATA] = data_ready_r;
    assign pending[MPHP_SRC_THR_EMPTY] = thr_irq_r;
    assign pending[MPHP_SRC_RX_ERR] = rx_err_r;
    assign pending[MPHP_SRC_MODEM] = |modem_delta_r;
    assign active = pending & irq_en_r;

    // Identification by priority: error, data, transmit, modem
    assign irq_id = active[MPHP_SRC_RX_ERR] ? MPHP_ID_RX_ERR :
                    active[MPHP_SRC_RX_DATA] ? MPHP_ID_RX_DATA :
                    active[MPHP_SRC_THR_EMPTY] ? MPHP_ID_THR_EMPTY :
                    active[MPHP_SRC_MODEM] ? MPHP_ID_MODEM : MPHP_ID_NONE;

    assign line_stat = (8'(thr_empty_r) << MPHP_LSR_THR_EMPTY) | (8'(rx_err_r) << MPHP_LSR_RX_ERR) |
                       (8'(data_ready_r) << MPHP_LSR_DATA_READY);

    // Read mux over the eight registers
    assign rd_value = (acc.index == MPHP_IDX_DATA) ? rx_data_r :
                      (acc.index == MPHP_IDX_IRQ_EN) ? {4'h0, irq_en_r} :
                      (acc.index == MPHP_IDX_IRQ_ID) ? irq_id :
                      (acc.index == MPHP_IDX_LINE_CTRL) ? line_ctrl_o :
                      (acc.index == MPHP_IDX_MODEM_CTRL) ? modem_ctrl_o :
                      (acc.index == MPHP_IDX_LINE_STAT) ? line_stat :
                      (acc.index == MPHP_IDX_MODEM_STAT) ? {modem_prev_r, modem_delta_r} : scratch_r;

    // Service clears; a new event in the same cycle wins over the clear
    assign data_ready_nxt = rx_valid_i | (data_ready_r & ~rd_data);
    assign rx_err_nxt = (rx_valid_i & rx_error_i) | (rx_err_r & ~rd_lsr);
    assign thr_empty_nxt = tx_done_i | (thr_empty_r & ~wr_data);
    assign thr_irq_nxt = tx_done_i | (thr_irq_r & ~wr_data & ~(rd_id & (irq_id == MPHP_ID_THR_EMPTY)));
    assign modem_delta_nxt = (modem_status_i ^ modem_prev_r) | (modem_delta_r & ~{4{rd_msr}});

    // Flags and status sampling
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            data_ready_r <= 1'b0;
            rx_err_r <= 1'b0;
            thr_empty_r <= MPHP_RST_THR_EMPTY;
            thr_irq_r <= 1'b0;
            modem_delta_r <= 4'h0;
            modem_prev_r <= 4'h0;
            rx_data_r <= MPHP_RST_BYTE;
        end else begin
            data_ready_r <= data_ready_nxt;
            rx_err_r <= rx_err_nxt;
            thr_empty_r <= thr_empty_nxt;
            thr_irq_r <= thr_irq_nxt;
            modem_delta_r <= modem_delta_nxt;
            modem_prev_r <= modem_status_i;
            rx_data_r <= rx_valid_i ? rx_data_i : rx_data_r;
        end
    end

    // Host writable registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_en_r <= MPHP_RST_IRQ_EN;
            line_ctrl_o <= MPHP_RST_BYTE;
            modem_ctrl_o <= MPHP_RST_BYTE;
            scratch_r <= MPHP_RST_BYTE;
            tx_data_o <= MPHP_RST_BYTE;
            tx_load_o <= 1'b0;
        end else begin
            irq_en_r <= (acc.wr_pulse && acc.index == MPHP_IDX_IRQ_EN) ? acc.wdata[3:0] : irq_en_r;
            line_ctrl_o <= (acc.wr_pulse && acc.index == MPHP_IDX_LINE_CTRL) ? acc.wdata : line_ctrl_o;
            modem_ctrl_o <= (acc.wr_pulse && acc.index == MPHP_IDX_MODEM_CTRL) ? acc.wdata : modem_ctrl_o;
            scratch_r <= (acc.wr_pulse && acc.index == MPHP_IDX_SCRATCH) ? acc.wdata : scratch_r;
            tx_data_o <= wr_data ? acc.wdata : tx_data_o;
            tx_load_o <= wr_data;
        end
    end

    // Bus drive and interrupt output; data is latched at strobe start
    // so that the read's own clear does not alter the byte mid-strobe
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            host_data_bus_o <= MPHP_RST_BYTE;
            host_data_bus_oe_o <= 1'b0;
            host_irq_o <= 1'b0;
        end else begin
            host_data_bus_o <= acc.rd_pulse ? rd_value : host_data_bus_o;
            host_data_bus_oe_o <= acc.rd_active;
            host_irq_o <= |active;
        end
    end

    sel_gate_a: assert property (host_select_n_i |-> !acc.wr_pulse && !acc.rd_pulse)
        else $error("access taken without chip select");
    scratch_store_a: assert property (acc.wr_pulse && acc.index == MPHP_IDX_SCRATCH |=>
        scratch_r == $past(host_data_bus_i))
        else $error("written byte not stored");
    read_drive_a: assert property (acc.rd_pulse |=> host_data_bus_oe_o && host_data_bus_o == $past(rd_value))
        else $error("read byte not driven");
    index_pick_a: assert property (acc.rd_pulse && host_reg_index_i == MPHP_IDX_LINE_STAT |=>
        host_data_bus_o == $past(line_stat))
        else $error("wrong register returned");
    bus_release_a: assert property (!host_select_n_i && !host_write_strobe_n_i |=> !host_data_bus_oe_o)
        else $error("data bus driven during write");
    irq_raise_a: assert property ((pending & irq_en_r) != 4'h0 |=> host_irq_o)
        else $error("interrupt not raised");
    // A fresh event in the service cycle may legally keep the interrupt up
    irq_clear_a: assert property (rd_data && !rx_valid_i && !tx_done_i &&
        modem_status_i == modem_prev_r && (active & 4'he) == 4'h0 |=> ##1 !host_irq_o)
        else $error("interrupt not cleared on service");
    settle_hold_a: assert property (!port_ready_o |-> !acc.wr_pulse && !acc.rd_pulse &&
        settle_cnt_r < SETTLE_CYCLES)
        else $error("access before settle time");
    settle_end_a: assert property ($rose(port_ready_o) |-> settle_cnt_r == 32'(SETTLE_CYCLES))
        else $error("ready at wrong cycle");
endmodule
`default_nettype wire

//--- tb/mphp_host_model.sv
// Host processor model driving the parallel port pins
`default_nettype none
module mphp_host_model (
    input wire logic clk_i,
    input wire logic [7:0] dev_data_i,
    input wire logic dev_oe_i,
    output logic sel_n_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic [2:0] idx_o,
    output logic [7:0] bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv = 8'h00;
    logic drv_en = 1'b0;
    logic [7:0] last = 8'h00;
    int clashes = 0;
    // Released bus has no pull, so show the inverse of its last level
    assign bus_o = dev_oe_i ? dev_data_i : (drv_en ? drv : ~last);
    // Track bus level and any fight between host and device drivers
    always @(posedge clk_i) begin
        last <= bus_o;
        if (dev_oe_i && drv_en) clashes <= clashes + 1;
    end
    initial begin
        sel_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        idx_o = 3'h0;
    end
    // One write cycle; strobe then idles one edge before any next access
    task automatic wr(input logic sel_n, input logic [2:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        sel_n_o = sel_n;
        wr_n_o = 1'b0;
        idx_o = idx;
        drv = d;
        drv_en = 1'b1;
        @(posedge clk_i);
        #1;
        sel_n_o = 1'b1;
        wr_n_o = 1'b1;
        drv_en = 1'b0;
    endtask
    // One read cycle; byte and enable sampled once settled after the taking edge
    task automatic rd(input logic sel_n, input logic [2:0] idx, output logic [7:0] v, output logic oe);
        @(posedge clk_i);
        #1;
        sel_n_o = sel_n;
        rd_n_o = 1'b0;
        idx_o = idx;
        @(posedge clk_i);
        #1;
        v = bus_o;
        oe = dev_oe_i;
        @(posedge clk_i);
        #1;
        sel_n_o = 1'b1;
        rd_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- tb/modem_parallel_host_port_test.sv
// Self-checking bench for the modem parallel host port
`default_nettype none
module modem_parallel_host_port_test import mphp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sel_n, wr_n, rd_n, oe, irq, tx_load, ready;
    logic [2:0] idx;
    logic [7:0] bus, dout, tx_data, line_ctrl, modem_ctrl;
    logic rx_valid = 1'b0;
    logic rx_error = 1'b0;
    logic tx_done = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic [3:0] modem_status = 4'h0;
    int mismatches = 0;
    int checks = 0;
    always #4 clk_sys = ~clk_sys;
    // Short settle count keeps the run brief
    mphp_host_port #(.SETTLE_CYCLES(16)) i_dut (.clk_sys_i(clk_sys), .rst_i(rst), .host_select_n_i(sel_n),
        .host_write_strobe_n_i(wr_n), .host_read_strobe_n_i(rd_n), .host_reg_index_i(idx),
        .host_data_bus_i(bus), .host_data_bus_o(dout), .host_data_bus_oe_o(oe), .host_irq_o(irq),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_error_i(rx_error), .tx_done_i(tx_done),
        .modem_status_i(modem_status), .tx_data_o(tx_data), .tx_load_o(tx_load), .line_ctrl_o(line_ctrl),
        .modem_ctrl_o(modem_ctrl), .port_ready_o(ready));
    mphp_host_model i_host (.clk_i(clk_sys), .dev_data_i(dout), .dev_oe_i(oe), .sel_n_o(sel_n),
        .wr_n_o(wr_n), .rd_n_o(rd_n), .idx_o(idx), .bus_o(bus));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Reset, then an early write that must be dropped before the port is ready
    task automatic t_reset;
        int n;
        rst = 1'b1;
        repeat (12) @(posedge clk_sys);
        #1;
        chk("irq in reset", 8'h00, irq);
        chk("ready in reset", 8'h00, ready);
        chk("oe in reset", 8'h00, oe);
        rst = 1'b0;
        i_host.wr(1'b0, MPHP_IDX_SCRATCH, 8'h3c);
        chk("ready early", 8'h00, ready);
        n = 0;
        while (ready !== 1'b1 && n < 64) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("ready", 8'h01, ready);
        $display("test reset done");
    endtask
    // Each of the four writable control indices keeps its own byte; read-only index ignores writes
    task automatic t_regs;
        logic [7:0] v;
        logic o;
        logic [2:0] tbl [4];
        tbl = '{MPHP_IDX_IRQ_EN, MPHP_IDX_LINE_CTRL, MPHP_IDX_MODEM_CTRL, MPHP_IDX_SCRATCH};
        i_host.rd(1'b0, MPHP_IDX_SCRATCH, v, o);
        chk("scratch after early write", 8'h00, v);
        for (int i = 0; i < 4; i++) i_host.wr(1'b0, tbl[i], {4'h0, 1'b1, tbl[i]});
        i_host.wr(1'b0, MPHP_IDX_MODEM_STAT, 8'hff);
        for (int i = 0; i < 4; i++) begin
            i_host.rd(1'b0, tbl[i], v, o);
            chk("readback", {4'h0, 1'b1, tbl[i]}, v);
            chk("oe on read", 8'h01, o);
        end
        chk("line ctrl", 8'h0b, line_ctrl);
        chk("modem ctrl", 8'h0c, modem_ctrl);
        i_host.rd(1'b0, MPHP_IDX_MODEM_STAT, v, o);
        chk("modem stat", 8'h00, v);
        i_host.rd(1'b0, MPHP_IDX_IRQ_ID, v, o);
        chk("id idle", MPHP_ID_NONE, v);
        i_host.wr(1'b0, MPHP_IDX_IRQ_EN, 8'h00);
        $display("test registers done");
    endtask
    // Strobes with select high must neither store nor drive
    task automatic t_select;
        logic [7:0] v;
        logic o;
        i_host.wr(1'b1, MPHP_IDX_SCRATCH, 8'hff);
        i_host.rd(1'b1, MPHP_IDX_SCRATCH, v, o);
        chk("oe deselected", 8'h00, o);
        i_host.rd(1'b0, MPHP_IDX_SCRATCH, v, o);
        chk("scratch kept", 8'h0f, v);
        $display("test select done");
    endtask
    // Write to index 0 hands the byte over for one cycle and clears THR empty
    task automatic t_tx;
        logic [7:0] v;
        logic o;
        i_host.rd(1'b0, MPHP_IDX_LINE_STAT, v, o);
        chk("line stat idle", 8'h01 << MPHP_LSR_THR_EMPTY, v);
        i_host.wr(1'b0, MPHP_IDX_DATA, 8'h96);
        chk("tx load", 8'h01, tx_load);
        chk("tx data", 8'h96, tx_data);
        @(posedge clk_sys);
        #1;
        chk("tx load end", 8'h00, tx_load);
        i_host.rd(1'b0, MPHP_IDX_LINE_STAT, v, o);
        chk("line stat loaded", 8'h00, v);
        $display("test transmit done");
    endtask
    // Event while masked stays quiet, enabling raises irq, service drops it
    task automatic t_irq(input logic [7:0] en, input int src, input logic [7:0] id, input logic [2:0] clr,
        input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] v;
        logic o;
        @(posedge clk_sys);
        #1;
        case (src)
            0: begin rx_data = 8'ha5; rx_valid = 1'b1; end
            1: tx_done = 1'b1;
            2: begin rx_valid = 1'b1; rx_error = 1'b1; end
            default: modem_status = 4'h5;
        endcase
        @(posedge clk_sys);
        #1;
        rx_valid = 1'b0;
        rx_error = 1'b0;
        tx_done = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("irq masked", 8'h00, irq);
        i_host.wr(1'b0, MPHP_IDX_IRQ_EN, en);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("irq set", 8'h01, irq);
        i_host.rd(1'b0, MPHP_IDX_IRQ_ID, v, o);
        chk("irq id", id, v);
        i_host.rd(1'b0, clr, v, o);
        chk("service read", exp, v & mask);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("irq cleared", 8'h00, irq);
        i_host.wr(1'b0, MPHP_IDX_IRQ_EN, 8'h00);
        $display("test interrupt %0d done", src);
    endtask
    // Pending irq then a reset in mid-run must drop it and clear the scratch register
    task automatic t_midrun;
        logic [7:0] v;
        logic o;
        i_host.wr(1'b0, MPHP_IDX_IRQ_EN, 8'h08);
        modem_status = 4'ha;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("irq before reset", 8'h01, irq);
        t_reset();
        i_host.rd(1'b0, MPHP_IDX_SCRATCH, v, o);
        chk("scratch after reset", MPHP_RST_BYTE, v);
        chk("irq after reset", 8'h00, irq);
        $display("test mid-run reset done");
    endtask
    initial begin
        #(8 * 5000);
        mismatches++;
        conclude();
    end
    initial begin
        t_reset();
        t_regs();
        t_select();
        t_tx();
        t_irq(8'h01, 0, MPHP_ID_RX_DATA, MPHP_IDX_DATA, 8'hff, 8'ha5);
        t_irq(8'h02, 1, MPHP_ID_THR_EMPTY, MPHP_IDX_IRQ_ID, 8'hff, MPHP_ID_NONE);
        t_irq(8'h04, 2, MPHP_ID_RX_ERR, MPHP_IDX_LINE_STAT, 8'h02, 8'h02);
        t_irq(8'h08, 3, MPHP_ID_MODEM, MPHP_IDX_MODEM_STAT, 8'hff, 8'h55);
        t_midrun();
        chk("bus clashes", 8'h00, i_host.clashes[7:0]);
        conclude();
    end
endmodule
`default_nettype wire
